// ### design/rse_regs.svh
// Sizes, pair codes and timing constants of the remote state exchange
`ifndef RSE_REGS_SVH
`define RSE_REGS_SVH

// Point counts
`define RSE_N_VO 96
`define RSE_N_EXT 32
`define RSE_N_OPER 128
`define RSE_OPER_W 7
`define RSE_N_PAIRS 128
`define RSE_N_PREDEF 32
`define RSE_N_USER 32
`define RSE_N_ROUT 64
`define RSE_N_RIN 32
`define RSE_N_PEERS 16
`define RSE_PEER_W 4
`define RSE_SEL_W 6

// Message field widths
`define RSE_ID_W 64
`define RSE_TTL_W 16
`define RSE_VLAN_W 12
`define RSE_APPID_W 16
`define RSE_HOLD_W 18

// Bit pair encodings
`define RSE_PAIR_ON 2'h2
`define RSE_PAIR_OFF 2'h1
`define RSE_PAIR_UNUSED 2'h0

// Update interval limits and default in seconds, ms scale, hold time constants
`define RSE_UPD_MIN_S 6'h01
`define RSE_UPD_MAX_S 6'h3c
`define RSE_UPD_DEFAULT_S 6'h3c
`define RSE_MS_PER_S 16'h03e8
`define RSE_HOLD_MULT 18'h00003
`define RSE_HOLD_MARGIN_MS 18'h003e8

// Millisecond tick timing
`define RSE_MS_NS 1000000
`define RSE_CLK_NS 20

`endif

// ### design/rse_pkg.sv
// Types shared by the remote state exchange modules
package rse_pkg;

    // Transport choice for the exchange
    typedef enum logic [1:0] {
        TRANSPORT_NONE = 2'h0,
        TRANSPORT_GSSE = 2'h1,
        TRANSPORT_GOOSE = 2'h2
    } transport_e;

    // Remote input default policy
    typedef enum logic [1:0] {
        POLICY_ON = 2'h0,
        POLICY_OFF = 2'h1,
        POLICY_LATEST_ON = 2'h2,
        POLICY_LATEST_OFF = 2'h3
    } policy_e;

    // Transmit scheduler states
    typedef enum logic [1:0] {
        SCH_BOOT = 2'h0,
        SCH_RUN = 2'h1,
        SCH_IDLE = 2'h2
    } sched_e;

    // Scheduler state
    typedef struct packed {
        sched_e st;
        logic [15:0] ms_cnt;
        logic send;
    } sched_s;

    // Peer tracker state
    typedef struct packed {
        logic [15:0][15:0] timer;
        logic [15:0] offline;
        logic [15:0] accept;
    } track_s;

    // Top level state
    typedef struct packed {
        logic [15:0] tick_cnt;
        logic ms_tick;
        logic [15:0] interval_ms;
        logic [95:0] vout;
        logic [95:0] vo_evt;
        logic [63:0] points;
        logic points_ok;
        logic change;
        logic [255:0] tx_pairs;
        logic tx_valid;
        logic tx_goose;
        logic [17:0] tx_hold_ms;
        logic [255:0] rx_hold;
        logic [15:0][63:0] peer_pts;
        logic [15:0] peer_known;
        logic [31:0] rin;
    } top_s;

endpackage

// ### design/xchg_if.sv
// Signals shared between the exchange core, scheduler and peer tracker
`timescale 1ns/100ps
interface xchg_if;
    logic ms_tick;            // One-cycle millisecond tick
    logic [15:0] interval_ms; // Default update interval in ms
    logic point_change;       // Transmitted point changed
    logic send;               // Transmit request pulse
    logic [15:0] offline;     // Per peer non-communicating
    logic [15:0] accept;      // Per peer accepted message pulse

    modport core (output ms_tick, output interval_ms, output point_change,
                  input send, input offline, input accept);
    modport sched (input ms_tick, input interval_ms, input point_change, output send);
    modport track (input ms_tick, output offline, output accept);
endinterface

// ### design/tx_scheduler.sv
// Decides when a state message is sent: boot, change, periodic
`timescale 1ns/100ps
`include "rse_regs.svh"
module tx_scheduler
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Transport choice
    input wire logic [1:0] transport,
    // Shared link to the core
    xchg_if.sched x
);

    rse_pkg::sched_s s;
    rse_pkg::sched_s next_s;

    assign x.send = s.send;

    // Next state of the scheduler
    always_comb
    begin
        next_s = s;
        next_s.send = 1'b0;
        case (s.st)
            // First message once transport is enabled
            rse_pkg::SCH_BOOT:
            begin
                if (transport != rse_pkg::TRANSPORT_NONE)
                begin
                    next_s.send = 1'b1;
                    next_s.ms_cnt = 16'h0000;
                    next_s.st = rse_pkg::SCH_RUN;
                end
            end
            // Change or interval driven sending
            rse_pkg::SCH_RUN:
            begin
                if (transport == rse_pkg::TRANSPORT_NONE)
                begin
                    next_s.st = rse_pkg::SCH_IDLE;
                end
                else if (x.point_change)
                begin
                    next_s.send = 1'b1;
                    next_s.ms_cnt = 16'h0000;
                end
                else if (x.ms_tick)
                begin
                    if (s.ms_cnt + 16'h0001 >= x.interval_ms)
                    begin
                        next_s.send = 1'b1;
                        next_s.ms_cnt = 16'h0000;
                    end
                    else
                    begin
                        next_s.ms_cnt = s.ms_cnt + 16'h0001;
                    end
                end
            end
            // Re-enabling transport behaves like a fresh start
            rse_pkg::SCH_IDLE:
            begin
                if (transport != rse_pkg::TRANSPORT_NONE)
                begin
                    next_s.st = rse_pkg::SCH_BOOT;
                end
            end
            default:
            begin
                next_s.st = rse_pkg::SCH_BOOT;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '{st: rse_pkg::SCH_BOOT, ms_cnt: 16'h0000, send: 1'b0};
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// ### design/peer_tracker.sv
// Filters received messages by originator and times out silent peers
`timescale 1ns/100ps
`include "rse_regs.svh"
module peer_tracker
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Transport choice
    input wire logic [1:0] transport,
    // Received message header
    input wire logic rx_valid,
    input wire logic rx_goose,
    input wire logic [`RSE_ID_W-1:0] rx_id,
    input wire logic [`RSE_VLAN_W-1:0] rx_vlan,
    input wire logic [`RSE_APPID_W-1:0] rx_appid,
    input wire logic [`RSE_TTL_W-1:0] rx_ttl_ms,
    // Peer table
    input wire logic [15:0][`RSE_ID_W-1:0] remote_peer_identifier,
    input wire logic [15:0][`RSE_VLAN_W-1:0] peer_vlan,
    input wire logic [15:0][`RSE_APPID_W-1:0] peer_application_identifier,
    // Shared link to the core
    xchg_if.track x
);

    rse_pkg::track_s s;
    rse_pkg::track_s next_s;
    logic [15:0] hit; // Message matches this peer entry

    assign x.offline = s.offline;
    assign x.accept = s.accept;

    // Per peer match of the received header
    genvar gi;
    generate
        for (gi = 0; gi < `RSE_N_PEERS; gi++)
        begin : g_match
            // VLAN and APPID only for GOOSE
            assign hit[gi] = rx_valid && (rx_id == remote_peer_identifier[gi]) &&
                ((transport == rse_pkg::TRANSPORT_GSSE && !rx_goose) ||
                 (transport == rse_pkg::TRANSPORT_GOOSE && rx_goose &&
                  rx_vlan == peer_vlan[gi] && rx_appid == peer_application_identifier[gi]));
        end
    endgenerate

    // Timer update per peer; a fresh message beats a timeout
    always_comb
    begin
        next_s = s;
        for (int i = 0; i < `RSE_N_PEERS; i++)
        begin
            next_s.accept[i] = hit[i];
            if (hit[i])
            begin
                next_s.timer[i] = rx_ttl_ms;
                next_s.offline[i] = (rx_ttl_ms == 16'h0000);
            end
            else if (x.ms_tick && !s.offline[i])
            begin
                if (s.timer[i] <= 16'h0001)
                begin
                    next_s.timer[i] = 16'h0000;
                    next_s.offline[i] = 1'b1;
                end
                else
                begin
                    next_s.timer[i] = s.timer[i] - 16'h0001;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '{timer: '0, offline: 16'hffff, accept: 16'h0000};
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// ### design/remote_state_exchange.sv
// Virtual outputs, state message build and remote input extraction
`timescale 1ns/100ps
`include "rse_regs.svh"

// What this block does
// - 96 virtual outputs, unassigned ones held low
// - Virtual outputs recomputed every evaluation pass
// - Enabled virtual outputs flag events on change
// - Message has 128 pairs, 32 predefined first
// - Only 32 user-status pairs are used
// - Send on power-up, change, and interval
// - Hold time above three update intervals
// - Accept only configured originator identifiers
// - Time-to-live timer per peer, expiry offline
// - Fresh message updates points, restarts timer
// - Per-peer offline status is readable
// - 32 remote inputs, 64 remote outputs
// - Sixteen peers, each exact identifier match
// - VLAN and APPID apply to GOOSE only
// - Input pair from 64 predefined/user choices
// - Input picks peer number and pair
// - Default state at startup and when offline
// - Fixed-on gives 1, fixed-off gives 0
// - Hold-last freezes value, resumes on return
// - Each remote output carries selected operand
// - GOOSE carries same points as GSSE
// - Update interval 1 to 60 seconds
// - Transport is GOOSE, GSSE or none
module remote_state_exchange
#(
    // Clock cycles per millisecond tick
    parameter int CYC_PER_MS = `RSE_MS_NS / `RSE_CLK_NS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Local programmable logic results
    input wire logic [`RSE_N_VO-1:0] vo_logic,
    input wire logic [`RSE_N_VO-1:0] vo_assigned,
    input wire logic [`RSE_N_VO-1:0] vo_event_en,
    input wire logic [`RSE_N_EXT-1:0] ext_operand,
    // Transmit configuration
    input wire logic [1:0] transport_selection,
    input wire logic [5:0] update_s,
    input wire logic [`RSE_N_ROUT-1:0][`RSE_OPER_W-1:0] rout_select,
    // Transmitted message
    output logic tx_valid,
    output logic tx_goose,
    output logic [2*`RSE_N_PAIRS-1:0] tx_pairs,
    output logic [`RSE_HOLD_W-1:0] tx_hold_ms,
    // Received message
    input wire logic rx_valid,
    input wire logic rx_goose,
    input wire logic [`RSE_ID_W-1:0] rx_id,
    input wire logic [`RSE_VLAN_W-1:0] rx_vlan,
    input wire logic [`RSE_APPID_W-1:0] rx_appid,
    input wire logic [`RSE_TTL_W-1:0] rx_ttl_ms,
    input wire logic [2*`RSE_N_PAIRS-1:0] rx_pairs,
    // Peer table
    input wire logic [15:0][`RSE_ID_W-1:0] remote_peer_identifier,
    input wire logic [15:0][`RSE_VLAN_W-1:0] peer_vlan,
    input wire logic [15:0][`RSE_APPID_W-1:0] peer_application_identifier,
    // Remote input configuration
    input wire logic [`RSE_N_RIN-1:0][`RSE_PEER_W-1:0] rin_device,
    input wire logic [`RSE_N_RIN-1:0][`RSE_SEL_W-1:0] rin_pair,
    input wire logic [`RSE_N_RIN-1:0][1:0] rin_policy,
    // Local results
    output logic [`RSE_N_VO-1:0] virtual_out,
    output logic [`RSE_N_VO-1:0] vo_event,
    output logic [`RSE_N_RIN-1:0] remote_in,
    output logic [`RSE_N_PEERS-1:0] peer_offline
);

    // Tick divider terminal count at the counter's width
    localparam logic [15:0] TICK_LAST = 16'(CYC_PER_MS - 1);

    rse_pkg::top_s s;         // Registered state
    rse_pkg::top_s next_s;    // Next state
    xchg_if x ();             // Link to scheduler and tracker
    logic [`RSE_N_OPER-1:0] operands; // Selectable operand pool
    logic [5:0] upd_clamped;  // Interval kept inside its range

    // Outputs come straight from the state register
    assign virtual_out = s.vout;
    assign vo_event = s.vo_evt;
    assign tx_valid = s.tx_valid;
    assign tx_goose = s.tx_goose;
    assign tx_pairs = s.tx_pairs;
    assign tx_hold_ms = s.tx_hold_ms;
    assign remote_in = s.rin;
    assign peer_offline = x.offline;

    // Drive the shared link
    assign x.ms_tick = s.ms_tick;
    assign x.interval_ms = s.interval_ms;
    assign x.point_change = s.change;

    // Operands offered to remote outputs: virtual outputs plus external ones
    assign operands = {ext_operand, s.vout};

    always_comb
    begin
        if (update_s < `RSE_UPD_MIN_S)
        begin
            upd_clamped = `RSE_UPD_MIN_S;
        end
        else if (update_s > `RSE_UPD_MAX_S)
        begin
            upd_clamped = `RSE_UPD_MAX_S;
        end
        else
        begin
            upd_clamped = update_s;
        end
    end

    // Periodic message timing
    tx_scheduler u_sched
    (
        .clk(clk),
        .rst(rst),
        .transport(transport_selection),
        .x(x.sched)
    );

    // Receive filter and peer timeouts
    peer_tracker u_track
    (
        .clk(clk),
        .rst(rst),
        .transport(transport_selection),
        .rx_valid(rx_valid),
        .rx_goose(rx_goose),
        .rx_id(rx_id),
        .rx_vlan(rx_vlan),
        .rx_appid(rx_appid),
        .rx_ttl_ms(rx_ttl_ms),
        .remote_peer_identifier(remote_peer_identifier),
        .peer_vlan(peer_vlan),
        .peer_application_identifier(peer_application_identifier),
        .x(x.track)
    );

    // All next-state logic of the core
    always_comb
    begin
        logic [`RSE_PEER_W-1:0] dev;
        logic live;
        dev = '0;
        live = 1'b0;
        next_s = s;

        // Millisecond tick shared by scheduler and timers
        if (s.tick_cnt >= TICK_LAST)
        begin
            next_s.tick_cnt = 16'h0000;
            next_s.ms_tick = 1'b1;
        end
        else
        begin
            next_s.tick_cnt = s.tick_cnt + 16'h0001;
            next_s.ms_tick = 1'b0;
        end
        next_s.interval_ms = 16'(upd_clamped) * `RSE_MS_PER_S;

        next_s.vout = vo_logic & vo_assigned;
        next_s.vo_evt = vo_event_en & (next_s.vout ^ s.vout);

        for (int k = 0; k < `RSE_N_ROUT; k++)
        begin
            next_s.points[k] = operands[rout_select[k]];
        end
        next_s.points_ok = 1'b1;
        // First sample after reset is not a change; boot covers it
        next_s.change = s.points_ok && (next_s.points != s.points);

        // Message build on a send request
        next_s.tx_valid = 1'b0;
        if (x.send)
        begin
            next_s.tx_valid = 1'b1;
            next_s.tx_goose = (transport_selection == rse_pkg::TRANSPORT_GOOSE);
            next_s.tx_hold_ms = 18'(s.interval_ms) * `RSE_HOLD_MULT + `RSE_HOLD_MARGIN_MS;
            for (int p = 0; p < `RSE_N_PAIRS; p++)
            begin
                // predefined pairs first, then user pairs
                // user pairs past the 32nd stay unused
                if (p < `RSE_N_PREDEF + `RSE_N_USER)
                begin
                    next_s.tx_pairs[2*p +: 2] = s.points[p] ? `RSE_PAIR_ON : `RSE_PAIR_OFF;
                end
                else
                begin
                    next_s.tx_pairs[2*p +: 2] = `RSE_PAIR_UNUSED;
                end
            end
        end

        // Hold the payload until the tracker's accept pulse a cycle later
        if (rx_valid)
        begin
            next_s.rx_hold = rx_pairs;
        end

        for (int i = 0; i < `RSE_N_PEERS; i++)
        begin
            if (x.accept[i])
            begin
                // all points of the peer refreshed
                for (int k = 0; k < `RSE_N_PREDEF + `RSE_N_USER; k++)
                begin
                    next_s.peer_pts[i][k] = (s.rx_hold[2*k +: 2] == `RSE_PAIR_ON);
                end
                next_s.peer_known[i] = 1'b1;
            end
        end

        // Remote input selection and default policy
        for (int j = 0; j < `RSE_N_RIN; j++)
        begin
            // peer number and pair pick the value
            dev = rin_device[j];
            // Offline clears with the accept pulse, a cycle before the stored copy
            if (x.accept[dev])
            begin
                // Read the held payload so no stale value shows
                live = (s.rx_hold[2*rin_pair[j] +: 2] == `RSE_PAIR_ON);
            end
            else
            begin
                live = s.peer_pts[dev][rin_pair[j]];
            end
            if (!x.offline[dev])
            begin
                next_s.rin[j] = live;
            end
            else
            begin
                case (rse_pkg::policy_e'(rin_policy[j]))
                    rse_pkg::POLICY_ON:
                    begin
                        next_s.rin[j] = 1'b1;
                    end
                    rse_pkg::POLICY_OFF:
                    begin
                        next_s.rin[j] = 1'b0;
                    end
                    rse_pkg::POLICY_LATEST_ON:
                    begin
                        next_s.rin[j] = s.peer_known[dev] ? live : 1'b1;
                    end
                    rse_pkg::POLICY_LATEST_OFF:
                    begin
                        next_s.rin[j] = s.peer_known[dev] ? live : 1'b0;
                    end
                    default:
                    begin
                        next_s.rin[j] = 1'b0;
                    end
                endcase
            end
        end
    end

    // State register; reset clears remote inputs, every policy's default follows a cycle later
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// ### verif/rse_checker_sva.sv
// Port-level assertions for the remote state exchange
`timescale 1ns/100ps
`include "rse_regs.svh"
module rse_checker
#(
    // Clock cycles per millisecond tick
    parameter int CYC_PER_MS = 10
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Virtual outputs
    input wire logic [`RSE_N_VO-1:0] vo_logic,
    input wire logic [`RSE_N_VO-1:0] vo_assigned,
    input wire logic [`RSE_N_VO-1:0] vo_event_en,
    input wire logic [`RSE_N_VO-1:0] virtual_out,
    input wire logic [`RSE_N_VO-1:0] vo_event,
    // Transmit side
    input wire logic [1:0] transport_selection,
    input wire logic [5:0] update_s,
    input wire logic tx_valid,
    input wire logic [`RSE_HOLD_W-1:0] tx_hold_ms,
    // Receive side
    input wire logic rx_valid,
    input wire logic rx_goose,
    input wire logic [`RSE_ID_W-1:0] rx_id,
    input wire logic [`RSE_TTL_W-1:0] rx_ttl_ms,
    input wire logic [15:0][`RSE_ID_W-1:0] remote_peer_identifier,
    input wire logic [`RSE_N_PEERS-1:0] peer_offline
);
    logic [5:0] secs; // Interval after clamping
    logic [17:0] hold_exp; // Expected hold time in ms

    // Clamp to 1..60 s, then three intervals plus margin
    always_comb
    begin
        secs = (update_s == 6'h00) ? 6'h01 : ((update_s > 6'h3c) ? 6'h3c : update_s);
        hold_exp = 18'(secs) * 18'h00bb8 + 18'h003e8;
    end

    // One clock domain, so one default for all
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // First edge after reset still sees reset-time inputs
    a_vo_follow: assert property (
        !$past(rst) |-> virtual_out == $past(vo_logic & vo_assigned))
        else $error("virtual output does not follow its logic");
    a_vo_event: assert property (
        !$past(rst) |-> vo_event == ($past(vo_event_en) & (virtual_out ^ $past(virtual_out))))
        else $error("virtual output event wrong");
    a_boot_send: assert property (
        $fell(rst) && transport_selection != 2'h0 |-> ##[0:4] tx_valid)
        else $error("no message after startup");
    a_hold_time: assert property (
        tx_valid |-> tx_hold_ms == hold_exp)
        else $error("hold time wrong");
    // A send already in flight may land just after switching off
    a_silent_none: assert property (
        transport_selection == 2'h0 && $past(transport_selection) == 2'h0
        && $past(transport_selection, 3) == 2'h0 |-> !tx_valid)
        else $error("message sent with no transport");
    a_accept_online: assert property (
        rx_valid && transport_selection == 2'h1 && !rx_goose && rx_ttl_ms != 16'h0000
        && rx_id == remote_peer_identifier[0] |=> !peer_offline[0])
        else $error("matching message not accepted");
    a_online_cause: assert property (
        $fell(peer_offline[0]) |-> $past(rx_valid))
        else $error("peer online without a message");
    a_reset_offline: assert property (
        disable iff (1'b0) rst |=> peer_offline == 16'hffff)
        else $error("peers not offline after reset");

    // Main scenarios reached
    c_send: cover property (tx_valid);
    c_online: cover property ($fell(peer_offline[0]));
    c_offline: cover property ($rose(peer_offline[0]));
endmodule

bind remote_state_exchange rse_checker #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.clk, .rst,
    .vo_logic, .vo_assigned, .vo_event_en, .virtual_out, .vo_event, .transport_selection,
    .update_s, .tx_valid, .tx_hold_ms, .rx_valid, .rx_goose, .rx_id, .rx_ttl_ms,
    .remote_peer_identifier, .peer_offline);

// ### verif/peer_relay.sv
// Stand-in for a remote relay sending state messages
`timescale 1ns/100ps
`include "rse_regs.svh"
module peer_relay
(
    // Clock
    input wire logic clk,
    // Message toward the block
    output logic rx_valid,
    output logic rx_goose,
    output logic [`RSE_ID_W-1:0] rx_id,
    output logic [`RSE_VLAN_W-1:0] rx_vlan,
    output logic [`RSE_APPID_W-1:0] rx_appid,
    output logic [`RSE_TTL_W-1:0] rx_ttl_ms,
    output logic [2*`RSE_N_PAIRS-1:0] rx_pairs
);
    // Quiet link; fields hold junk, never a valid copy
    initial
    begin
        rx_valid = 1'b0;
        rx_goose = 1'b0;
        rx_id = '1;
        rx_vlan = 12'h000;
        rx_appid = 16'h0000;
        rx_ttl_ms = 16'h0000;
        rx_pairs = '1;
    end

    // Pairs coded 10 on, 01 off
    task send(input logic [63:0] id, input logic [15:0] ttl, input logic [255:0] pairs);
        rx_id = id;
        rx_ttl_ms = ttl;
        rx_pairs = pairs;
        rx_valid = 1'b1;
        @(posedge clk);
        #1;
        // Released id and pairs flip so a stale sample shows
        rx_valid = 1'b0;
        rx_id = ~id;
        rx_pairs = ~pairs;
    endtask

    // GOOSE form carries VLAN and APPID tags
    task send_goose(input logic [63:0] id, input logic [11:0] vlan, input logic [15:0] appid);
        rx_goose = 1'b1;
        rx_vlan = vlan;
        rx_appid = appid;
        send(id, 16'h0014, '0);
        rx_goose = 1'b0;
        rx_vlan = ~vlan;
        rx_appid = ~appid;
    endtask
endmodule

// ### verif/test_remote_state_exchange.sv
// Self-checking bench for the remote state exchange
`timescale 1ns/100ps
`include "rse_regs.svh"
module test_remote_state_exchange;
    logic clk = 1'b0; // 50 MHz clock
    logic rst = 1'b1; // Held at start
    logic [95:0] vo_logic, vo_assigned, vo_event_en, virtual_out, vo_event;
    logic [31:0] ext_operand, remote_in;
    logic [1:0] transport_selection;
    logic [5:0] update_s;
    logic [63:0][6:0] rout_select;
    logic tx_valid, tx_goose, rx_valid, rx_goose;
    logic [255:0] tx_pairs, rx_pairs;
    logic [17:0] tx_hold_ms;
    logic [63:0] rx_id;
    logic [11:0] rx_vlan;
    logic [15:0] rx_appid, rx_ttl_ms, peer_offline;
    logic [15:0][63:0] remote_peer_identifier;
    logic [15:0][11:0] peer_vlan;
    logic [15:0][15:0] peer_application_identifier;
    logic [31:0][3:0] rin_device;
    logic [31:0][5:0] rin_pair;
    logic [31:0][1:0] rin_policy;
    int fails = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    int wn; // Cycles waited for a send
    localparam logic [63:0] ODD_ON = 64'h9999999999999999; // Odd pairs on

    // Short millisecond keeps timeouts quick
    remote_state_exchange #(.CYC_PER_MS(10)) dut_u (.*);
    peer_relay pr_u (.clk, .rx_valid, .rx_goose, .rx_id, .rx_vlan, .rx_appid,
        .rx_ttl_ms, .rx_pairs);

    // Clock
    always #10 clk = ~clk;

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task chk(input logic [255:0] got, input logic [255:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for a message pulse
    task wait_tx(input int lim);
        wn = 0;
        while (tx_valid !== 1'b1 && wn < lim)
        begin
            tick(1);
            wn++;
        end
    endtask

    task summarize;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {vo_logic, vo_assigned, vo_event_en, ext_operand} = '0;
        transport_selection = 2'h1;
        update_s = 6'h01;
        for (int k = 0; k < 64; k++)
            rout_select[k] = (k < 32) ? 7'(k) : 7'(k + 64);
        for (int i = 0; i < 16; i++)
        begin
            remote_peer_identifier[i] = 64'h1000 + 64'(i);
            peer_vlan[i] = 12'h0a5;
            peer_application_identifier[i] = 16'h5a5a;
        end
        for (int j = 0; j < 32; j++)
        begin
            rin_device[j] = 4'h0;
            rin_pair[j] = 6'(j);
            rin_policy[j] = 2'(j % 4);
        end
        // One input from peer 4, one from user pair 1
        rin_device[30] = 4'h3;
        rin_pair[31] = 6'h20;
        tick(6);
        rst = 1'b0;
        tick(1);
        chk(peer_offline, 16'hffff);
        wait_tx(10);
        chk(wn < 10, 1'b1);
        chk(tx_hold_ms, 18'h00fa0);
        chk(tx_pairs, {128'h0, {64{2'h1}}});
        tick(2);
        chk(remote_in, 32'h55555555);
        // Top output unassigned but event-enabled
        vo_logic = '1;
        vo_assigned = {1'b0, {95{1'b1}}};
        vo_event_en = {1'b1, 95'h8};
        tick(1);
        chk(virtual_out, {1'b0, {95{1'b1}}});
        chk(vo_event, 96'h8);
        ext_operand = 32'h1;
        tick(1);
        chk(vo_event, 96'h0);
        wait_tx(20);
        chk(tx_pairs, {128'h0, 64'h5555555555555556, {32{2'h2}}});
        tick(1);
        wait_tx(10100);
        chk(wn >= 9980 && wn <= 10020, 1'b1);
        tick(1);
        transport_selection = 2'h0;
        wait_tx(11000);
        chk(wn, 11000);
        transport_selection = 2'h2;
        wait_tx(10);
        chk({wn < 10, tx_goose}, 2'h3);
        chk(tx_pairs, {128'h0, 64'h5555555555555556, {32{2'h2}}});
        tick(1);
        transport_selection = 2'h1;
        tick(3);
        pr_u.send(64'h77, 16'd5, {192'h0, ODD_ON});
        tick(4);
        chk({peer_offline, remote_in}, {16'hffff, 32'h55555555});
        pr_u.send(64'h1000, 16'd5, {192'h0, ODD_ON});
        tick(4);
        chk(peer_offline, 16'hfffe);
        chk(remote_in, 32'h6aaaaaaa);
        tick(70);
        chk(peer_offline[0], 1'b1);
        chk(remote_in, 32'h59999999);
        pr_u.send(64'h1000, 16'd5, {192'h0, {32{2'h1}}});
        tick(4);
        chk({peer_offline, remote_in}, {16'hfffe, 32'h40000000});
        // GOOSE needs matching tags; a GSSE frame is ignored then
        transport_selection = 2'h2;
        pr_u.send(64'h1001, 16'h0005, '0);
        tick(1);
        pr_u.send_goose(64'h1002, 12'h0a5, 16'h5a5b);
        tick(1);
        pr_u.send_goose(64'h1003, 12'h0a5, 16'h5a5a);
        tick(2);
        chk(peer_offline, 16'hfff6);
        chk(remote_in, 32'h0);
        summarize();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #(60000 * 20);
        fails++;
        summarize();
    end
endmodule
